// [cshtr_regs.sv]
// Carkit status, carkit latch and Hi-Speed tuning registers
// How it works
// - Status register at 20h is read only; writes ignored.
// - Status bit 1 mirrors data-line comparator, valid with sink enabled.
// - Carkit DP status and latch bits always read zero.
// - Status bits 5:3 carry the ID resistor conversion code.
// - Status bit 6 sets when the 282us conversion ends.
// - Done flag clears when result is read via vendor conversion register.
// - Reading result via status register leaves done flag alone.
// - Latch register at 21h is read only and clears on read.
// - Latch bit 0 sets on ID going floating with rise enable.
// - Latch bit 0 sets on ID leaving floating with fall enable.
// - Latch bit 1 sets on comparator change with its enable.
// - Latch bit 3 sets on done rising with conversion enable.
// - Addresses 30h to 3Fh form the vendor register range.
// - Registers are served through immediate register reads and writes.
// - Compensation register at 31h is read and write.
// - Bits 1:0 pick squelch threshold, reset to 00.
// - Bits 6:4 raise transmit amplitude, reset to 000.
// - Any enabled latched event raises the alt_int indication.
// - Conversion interrupt enable is OR of both enable bits.
// - Start launches a measurement; start clears itself at completion.
`timescale 1ns/1ps
module cshtr_regs #(
   parameter int CONV_CYCLES = cshtr_pkg::CONV_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic id_line_floating,
   input wire logic data_line_voltage_detect,
   input wire logic [2:0] id_resistor_sense,
   input wire logic data_sink_current_enable,
   input wire logic float_rise_irq_enable,
   input wire logic float_fall_irq_enable,
   input wire logic voltage_detect_irq_enable,
   input wire logic resistor_measure_irq_enable,
   input wire logic vendor_measure_irq_enable,
   input wire logic resistor_measure_launch,
   output logic resistor_measure_busy,
   output logic alt_int,
   output logic [1:0] squelch_threshold_select,
   output logic [2:0] hs_drive_amplitude_select
);
   localparam int NSYNC = 5;

   // ****************************************
   // Declarations
   // ****************************************
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] pin_filt;
   logic vdat_gated;
   logic vdat_prev_ff;
   logic float_prev_ff;
   logic [3:0] latch_ff;
   logic [3:0] latch_set;
   logic [3:0] nxt_latch;
   logic done_ff;
   logic nxt_done;
   logic rid_irq_en;
   logic rd_status;
   logic rd_latch;
   logic rd_view;
   logic wr_comp;
   logic vendor_hit;
   logic [7:0] status_val;
   logic [7:0] comp_val;
   logic [7:0] view_val;
   logic [7:0] nxt_rdata;
   logic [7:0] rdata_ff;
   logic rvalid_ff;
   logic alt_int_ff;
   logic [1:0] squelch_ff;
   logic [2:0] amp_ff;
   cshtr_conv_if conv ();

   // ****************************************
   // Pin synchronisers
   // ****************************************
   assign pin_raw = {id_resistor_sense, data_line_voltage_detect,
      id_line_floating};

   generate
      for (genvar i = 0; i < NSYNC; i++) begin : g_sync
         logic s1_ff;
         logic s2_ff;
         logic s3_ff;
         logic filt_ff;
         always_ff @(posedge clk) begin
            if (rst) begin
               s1_ff <= 1'b0;
               s2_ff <= 1'b0;
               s3_ff <= 1'b0;
            end else begin
               s1_ff <= pin_raw[i];
               s2_ff <= s1_ff;
               s3_ff <= s2_ff;
            end
         end
         always_ff @(posedge clk) begin
            if (rst) begin
               filt_ff <= 1'b0;
            end else if (s2_ff == s3_ff) begin
               filt_ff <= s3_ff;
            end
         end
         assign pin_filt[i] = filt_ff;
      end
   endgenerate

   assign vdat_gated = pin_filt[1] & data_sink_current_enable;

   // ****************************************
   // Address decode
   // ****************************************
   // Immediate access decode
   always_comb begin
      rd_status = 1'b0;
      rd_latch = 1'b0;
      rd_view = 1'b0;
      wr_comp = 1'b0;
      if (reg_rd && reg_addr == cshtr_pkg::ADDR_CARKIT_EVENT_STATUS) begin
         rd_status = 1'b1;
      end else if (reg_rd && reg_addr == cshtr_pkg::ADDR_CARKIT_EVENT_LATCH) begin
         rd_latch = 1'b1;
      end else if (reg_rd && reg_addr == cshtr_pkg::ADDR_RES_MEASURE_VIEW) begin
         rd_view = 1'b1;
      end else if (reg_wr && reg_addr == cshtr_pkg::ADDR_HS_SIGNAL_COMP) begin
         wr_comp = 1'b1;
      end
   end

   assign vendor_hit = reg_addr >= cshtr_pkg::ADDR_VENDOR_LO &&
      reg_addr <= cshtr_pkg::ADDR_VENDOR_HI;

   // ****************************************
   // Resistor conversion
   // ****************************************
   assign conv.start = resistor_measure_launch;
   assign conv.sense = pin_filt[4:2];

   cshtr_rid_conv #(
      .CONV_CYCLES(CONV_CYCLES)
   ) u_conv (
      .clk(clk),
      .rst(rst),
      .conv(conv)
   );

   // Clear on vendor read, set wins
   always_comb begin
      nxt_done = done_ff;
      if (rd_view) begin
         nxt_done = 1'b0;
      end
      if (conv.done_pulse) begin
         nxt_done = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         done_ff <= 1'b0;
      end else begin
         done_ff <= nxt_done;
      end
   end

   // ****************************************
   // Event latches
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         float_prev_ff <= 1'b0;
         vdat_prev_ff <= 1'b0;
      end else begin
         float_prev_ff <= pin_filt[0];
         vdat_prev_ff <= vdat_gated;
      end
   end

   assign rid_irq_en = resistor_measure_irq_enable | vendor_measure_irq_enable;

   always_comb begin
      latch_set = 4'h0;
      if (pin_filt[0] && !float_prev_ff && float_rise_irq_enable) begin
         latch_set[cshtr_pkg::LT_ID_FLOAT] = 1'b1;
      end
      if (!pin_filt[0] && float_prev_ff && float_fall_irq_enable) begin
         latch_set[cshtr_pkg::LT_ID_FLOAT] = 1'b1;
      end
      if (vdat_gated != vdat_prev_ff && voltage_detect_irq_enable) begin
         latch_set[cshtr_pkg::LT_VDAT] = 1'b1;
      end
      if (nxt_done && !done_ff && rid_irq_en) begin
         latch_set[cshtr_pkg::LT_RES_DONE] = 1'b1;
      end
   end

   assign nxt_latch = (rd_latch ? cshtr_pkg::LATCH_RESET : latch_ff) | latch_set;

   always_ff @(posedge clk) begin
      if (rst) begin
         latch_ff <= cshtr_pkg::LATCH_RESET;
      end else begin
         latch_ff <= nxt_latch;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         alt_int_ff <= 1'b0;
      end else begin
         alt_int_ff <= |latch_ff;
      end
   end

   // ****************************************
   // Compensation register
   // ****************************************
   // Writable tuning fields
   always_ff @(posedge clk) begin
      if (rst) begin
         squelch_ff <= cshtr_pkg::SQUELCH_RESET;
         amp_ff <= cshtr_pkg::AMPLITUDE_RESET;
      end else if (wr_comp) begin
         squelch_ff <= reg_wdata[cshtr_pkg::COMP_SQ_LO +: 2];
         amp_ff <= reg_wdata[cshtr_pkg::COMP_AMP_LO +: 3];
      end
   end

   // ****************************************
   // Read data
   // ****************************************
   // Status image, no write path
   always_comb begin
      status_val = 8'h00;
      status_val[cshtr_pkg::ST_ID_FLOAT] = pin_filt[0];
      status_val[cshtr_pkg::ST_VDAT] = vdat_gated;
      status_val[cshtr_pkg::ST_CARKIT_DP] = 1'b0;
      status_val[cshtr_pkg::ST_CODE_LO +: 3] = conv.code;
      status_val[cshtr_pkg::ST_DONE] = done_ff;
      comp_val = 8'h00;
      comp_val[cshtr_pkg::COMP_SQ_LO +: 2] = squelch_ff;
      comp_val[cshtr_pkg::COMP_AMP_LO +: 3] = amp_ff;
      view_val = 8'h00;
      view_val[2:0] = conv.code;
      view_val[cshtr_pkg::VW_DONE] = done_ff;
      view_val[cshtr_pkg::VW_LAUNCH] = conv.busy;
      view_val[cshtr_pkg::VW_IRQ_EN] = vendor_measure_irq_enable;
   end

   always_comb begin
      nxt_rdata = 8'h00;
      if (rd_status) begin
         nxt_rdata = status_val;
      end else if (rd_latch) begin
         nxt_rdata = {4'h0, latch_ff};
      end else if (rd_view) begin
         nxt_rdata = view_val;
      end else if (reg_rd && vendor_hit &&
            reg_addr == cshtr_pkg::ADDR_HS_SIGNAL_COMP) begin
         nxt_rdata = comp_val;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_ff <= cshtr_pkg::RDATA_RESET;
         rvalid_ff <= 1'b0;
      end else begin
         rdata_ff <= reg_rd ? nxt_rdata : rdata_ff;
         rvalid_ff <= reg_rd;
      end
   end

   assign reg_rdata = rdata_ff;
   assign reg_rvalid = rvalid_ff;
   assign alt_int = alt_int_ff;
   assign squelch_threshold_select = squelch_ff;
   assign hs_drive_amplitude_select = amp_ff;
   assign resistor_measure_busy = conv.busy;

   // ****************************************
   // Checks
   // ****************************************
   a_latch_read_clear: assert property (
      @(posedge clk) disable iff (rst)
      rd_latch && latch_set == 4'h0 |=> latch_ff == 4'h0)
      else $error("latch not cleared by read");
   a_latch_event_kept: assert property (
      @(posedge clk) disable iff (rst)
      rd_latch && latch_set != 4'h0 |=>
         (latch_ff & $past(latch_set)) == $past(latch_set))
      else $error("event lost during latch read");
   a_latch_rsvd_zero: assert property (
      @(posedge clk) disable iff (rst)
      rd_latch |=> reg_rdata[7:4] == 4'h0 && reg_rdata[2] == 1'b0)
      else $error("reserved latch bits not zero");
   a_alt_int_follow: assert property (
      @(posedge clk) disable iff (rst)
      latch_set != 4'h0 |=> ##1 alt_int)
      else $error("alt_int missing after event");
   a_done_vendor_clr: assert property (
      @(posedge clk) disable iff (rst)
      rd_view && !conv.done_pulse |=> !done_ff)
      else $error("done not cleared by vendor read");
   a_done_status_keep: assert property (
      @(posedge clk) disable iff (rst)
      rd_status && done_ff |=> done_ff && reg_rdata[6])
      else $error("status read disturbed done");
   a_rid_latch_set: assert property (
      @(posedge clk) disable iff (rst)
      conv.done_pulse && !done_ff && rid_irq_en |=> latch_ff[3])
      else $error("conversion latch not set");
   a_comp_write_back: assert property (
      @(posedge clk) disable iff (rst)
      wr_comp |=> squelch_threshold_select == $past(reg_wdata[1:0]) &&
         hs_drive_amplitude_select == $past(reg_wdata[6:4]))
      else $error("compensation write lost");
   a_vdat_status_bit: assert property (
      @(posedge clk) disable iff (rst)
      rd_status |=> reg_rdata[1] == $past(vdat_gated))
      else $error("comparator bit mismatch");
endmodule // cshtr_regs

// [cshtr_pkg.sv]
// Constants for the carkit status and Hi-Speed tuning register bank
package cshtr_pkg;
   // ****************************************
   // Register addresses
   // ****************************************
   localparam logic [5:0] ADDR_CARKIT_EVENT_STATUS = 6'h20;
   localparam logic [5:0] ADDR_CARKIT_EVENT_LATCH = 6'h21;
   localparam logic [5:0] ADDR_HS_SIGNAL_COMP = 6'h31;
   localparam logic [5:0] ADDR_RES_MEASURE_VIEW = 6'h36;
   localparam logic [5:0] ADDR_VENDOR_LO = 6'h30;
   localparam logic [5:0] ADDR_VENDOR_HI = 6'h3f;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int ST_ID_FLOAT = 0;
   localparam int ST_VDAT = 1;
   localparam int ST_CARKIT_DP = 2;
   localparam int ST_CODE_LO = 3;
   localparam int ST_DONE = 6;
   localparam int LT_ID_FLOAT = 0;
   localparam int LT_VDAT = 1;
   localparam int LT_CARKIT_DP = 2;
   localparam int LT_RES_DONE = 3;
   localparam int COMP_SQ_LO = 0;
   localparam int COMP_AMP_LO = 4;
   localparam int VW_DONE = 3;
   localparam int VW_LAUNCH = 4;
   localparam int VW_IRQ_EN = 6;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [1:0] SQUELCH_RESET = 2'h0;
   localparam logic [2:0] AMPLITUDE_RESET = 3'h0;
   localparam logic [2:0] CODE_RESET = 3'h0;
   localparam logic [3:0] LATCH_RESET = 4'h0;
   localparam logic [7:0] RDATA_RESET = 8'h00;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_PS = 5000;
   localparam int CONV_TIME_US = 282;
   localparam int CONV_CYCLES =
      (CONV_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CONV_CNT_W = 17;
endpackage

// [cshtr_conv_if.sv]
// Signals between register bank and resistor converter
`timescale 1ns/1ps
interface cshtr_conv_if;
   logic start;
   logic busy;
   logic done_pulse;
   logic [2:0] code;
   logic [2:0] sense;

   modport ctl (output start, output sense, input busy, input done_pulse,
      input code);
   modport cnv (input start, input sense, output busy, output done_pulse,
      output code);
endinterface

// [cshtr_rid_conv.sv]
// ID resistor conversion timer and result capture
`timescale 1ns/1ps
module cshtr_rid_conv #(
   parameter int CONV_CYCLES = cshtr_pkg::CONV_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   cshtr_conv_if.cnv conv
);
   logic [cshtr_pkg::CONV_CNT_W-1:0] cnt_ff;
   logic busy_ff;
   logic done_ff;
   logic [2:0] code_ff;

   // ****************************************
   // Conversion timer
   // ****************************************
   // Launch and self clear
   always_ff @(posedge clk) begin
      if (rst) begin
         busy_ff <= 1'b0;
         cnt_ff <= '0;
      end else if (conv.start) begin
         busy_ff <= 1'b1;
         cnt_ff <= cshtr_pkg::CONV_CNT_W'(CONV_CYCLES);
      end else if (busy_ff && cnt_ff == 1) begin
         busy_ff <= 1'b0;
         cnt_ff <= '0;
      end else if (busy_ff) begin
         cnt_ff <= cnt_ff - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         done_ff <= 1'b0;
      end else begin
         done_ff <= busy_ff && cnt_ff == 1 && !conv.start;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         code_ff <= cshtr_pkg::CODE_RESET;
      end else if (busy_ff && cnt_ff == 1 && !conv.start) begin
         code_ff <= conv.sense;
      end
   end

   assign conv.busy = busy_ff;
   assign conv.done_pulse = done_ff;
   assign conv.code = code_ff;

   // ****************************************
   // Checks
   // ****************************************
   a_conv_start_busy: assert property (
      @(posedge clk) disable iff (rst)
      conv.start |=> busy_ff && cnt_ff == cshtr_pkg::CONV_CNT_W'(CONV_CYCLES))
      else $error("conversion did not start");
   a_conv_end_done: assert property (
      @(posedge clk) disable iff (rst)
      busy_ff && cnt_ff == 1 && !conv.start |=> done_ff && !busy_ff)
      else $error("conversion end without done");
endmodule // cshtr_rid_conv

// [cshtr_link_model.sv]
// Link controller model issuing immediate register accesses
`timescale 1ns/1ps
module cshtr_link_model (
   input wire logic clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [5:0] reg_addr,
   output logic [7:0] reg_wdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 6'h00;
      reg_wdata = 8'h00;
   end

   // ****************************************
   // Register access
   // ****************************************
   // Immediate read or write
   task automatic xfer(input logic w, input logic [5:0] a,
      input logic [7:0] d);
      reg_wr = w;
      reg_rd = ~w;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
endmodule // cshtr_link_model

// [test_cshtr_regs.sv]
// Testbench for the carkit status and tuning register bank
`timescale 1ns/1ps
module test_cshtr_regs;
   localparam int CONV = 20;
   logic clk, rst, idf, vdat, sink, rise_en, fall_en, vd_en, res_en;
   logic vend_en, launch, reg_wr, reg_rd, reg_rvalid, busy, alt_int;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic [2:0] sense, code_exp, amp;
   logic [1:0] sq;
   logic done_exp;
   logic [7:0] exp_q[$];
   logic [3:0] id_tab [4] = '{4'b1011, 4'b1000, 4'b0110, 4'b0101};
   int bad_count = 0;
   int tests_run = 0;
   int k, j;

   cshtr_regs #(.CONV_CYCLES(CONV)) cshtr_regs_i (.clk(clk), .rst(rst),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .id_line_floating(idf),
      .data_line_voltage_detect(vdat), .id_resistor_sense(sense),
      .data_sink_current_enable(sink), .float_rise_irq_enable(rise_en),
      .float_fall_irq_enable(fall_en), .voltage_detect_irq_enable(vd_en),
      .resistor_measure_irq_enable(res_en),
      .vendor_measure_irq_enable(vend_en),
      .resistor_measure_launch(launch), .resistor_measure_busy(busy),
      .alt_int(alt_int), .squelch_threshold_select(sq),
      .hs_drive_amplitude_select(amp));

   cshtr_link_model cshtr_link_model_i (.clk(clk), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

   // ****************************************
   // Helpers
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic stop_test();
      $display("compares %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk_data(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected read at %0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic chk_pin(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected pin at %0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      cshtr_link_model_i.xfer(1'b0, a, 8'h00);
      step(1);
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      cshtr_link_model_i.xfer(1'b1, a, v);
      step(1);
   endtask

   function automatic logic [7:0] st();
      return {1'b0, done_exp, code_exp, 1'b0, vdat & sink, idf};
   endfunction

   // ****************************************
   // Read data monitor
   // ****************************************
   always @(negedge clk) begin
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk_data(reg_rdata, 8'hxx);
         end else begin
            chk_data(reg_rdata, exp_q.pop_front());
         end
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {rst, idf, vdat, sink, rise_en, fall_en, vd_en} = 7'h40;
      {res_en, vend_en, launch, sense} = 6'h00;
      {code_exp, done_exp} = 4'h0;
      void'($urandom(32'hb73aba6f));
      step(10);
      rst = 1'b0;
      step(5);
      rd(6'h20, 8'h00);
      rd(6'h21, 8'h00);
      rd(6'h31, 8'h00);
      rd(6'h3f, 8'h00);
      rd(6'h10, 8'h00);
      chk_pin({5'h00, amp}, 8'h00);
      for (k = 0; k < 6; k++) begin
         d = 8'($urandom);
         wr(6'h31, d);
         chk_pin({6'h00, sq}, {6'h00, d[1:0]});
         chk_pin({5'h00, amp}, {5'h00, d[6:4]});
         rd(6'h31, d & 8'h73);
      end
      wr(6'h20, 8'hff);
      wr(6'h21, 8'hff);
      rd(6'h20, 8'h00);
      sink = 1'b1;
      vd_en = 1'b1;
      vdat = 1'b1;
      step(10);
      chk_pin({7'h00, alt_int}, 8'h01);
      rd(6'h20, st());
      rd(6'h21, 8'h02);
      step(3);
      chk_pin({7'h00, alt_int}, 8'h00);
      rd(6'h21, 8'h00);
      vd_en = 1'b0;
      sink = 1'b0;
      vdat = 1'b0;
      step(10);
      rd(6'h20, st());
      rd(6'h21, 8'h00);
      sink = 1'b1;
      vd_en = 1'b1;
      for (k = 0; k < 4; k++) begin
         {rise_en, fall_en, idf} = id_tab[k][3:1];
         step(10);
         rd(6'h21, {7'h00, id_tab[k][0]});
      end
      for (j = 0; j < 3; j++) begin
         res_en = (j == 0);
         vend_en = (j == 1);
         sense = 3'($urandom);
         step(6);
         launch = 1'b1;
         step(1);
         launch = 1'b0;
         chk_pin({7'h00, busy}, 8'h01);
         for (k = 0; k < 100 && busy === 1'b1; k++) step(1);
         if (busy !== 1'b0) begin
            bad_count++;
            stop_test();
         end
         step(4);
         code_exp = sense;
         done_exp = 1'b1;
         chk_pin({7'h00, alt_int}, {7'h00, j < 2});
         rd(6'h20, st());
         rd(6'h20, st());
         rd(6'h21, {4'h0, j < 2, 3'h0});
         rd(6'h36, {1'b0, vend_en, 2'h0, 1'b1, code_exp});
         done_exp = 1'b0;
         rd(6'h20, st());
      end
      res_en = 1'b1;
      launch = 1'b1;
      step(1);
      launch = 1'b0;
      step(CONV);
      rd(6'h21, 8'h00);
      rd(6'h21, 8'h08);
      for (k = 0; k < 20 && exp_q.size() > 0; k++) step(1);
      if (exp_q.size() > 0) begin
         bad_count++;
      end
      stop_test();
   end
endmodule // test_cshtr_regs
